// File: hdl/tcc_pkg.sv
package tcc_pkg;

   // ----------------------------------------
   // Register byte addresses, one byte per word
   // ----------------------------------------
   localparam logic [7:0] ADR_CTRL_ONE  = 8'h00;
   localparam logic [7:0] ADR_CTRL_TWO  = 8'h04;
   localparam logic [7:0] ADR_STATUS    = 8'h08;
   localparam logic [7:0] ADR_CAP1_HI   = 8'h0C;
   localparam logic [7:0] ADR_CAP1_LO   = 8'h10;
   localparam logic [7:0] ADR_CAP2_HI   = 8'h14;
   localparam logic [7:0] ADR_CAP2_LO   = 8'h18;
   localparam logic [7:0] ADR_CMP1_HI   = 8'h1C;
   localparam logic [7:0] ADR_CMP1_LO   = 8'h20;
   localparam logic [7:0] ADR_CMP2_HI   = 8'h24;
   localparam logic [7:0] ADR_CMP2_LO   = 8'h28;
   localparam logic [7:0] ADR_CNT_HI    = 8'h2C;
   localparam logic [7:0] ADR_CNT_LO    = 8'h30;
   localparam logic [7:0] ADR_ACNT_HI   = 8'h34;
   localparam logic [7:0] ADR_ACNT_LO   = 8'h38;

   // ----------------------------------------
   // Control one fields
   // ----------------------------------------
   localparam int C1_CAP_IRQ_EN  = 7;
   localparam int C1_CMP_IRQ_EN  = 6;
   localparam int C1_WRAP_IRQ_EN = 5;
   localparam int C1_FORCE2      = 4;
   localparam int C1_FORCE1      = 3;
   localparam int C1_LEVEL2      = 2;
   localparam int C1_CAP1_EDGE   = 1;
   localparam int C1_LEVEL1      = 0;

   // ----------------------------------------
   // Control two fields
   // ----------------------------------------
   localparam int C2_PIN1_EN     = 7;
   localparam int C2_PIN2_EN     = 6;
   localparam int C2_SINGLE      = 5;
   localparam int C2_PWIDTH      = 4;
   localparam int C2_CLK_SEL_HI  = 3;
   localparam int C2_CLK_SEL_LO  = 2;
   localparam int C2_CAP2_EDGE   = 1;
   localparam int C2_EXT_EDGE    = 0;

   // ----------------------------------------
   // Flag vector index, status bit is index plus three
   // ----------------------------------------
   localparam int F_CMP2 = 0;
   localparam int F_CAP2 = 1;
   localparam int F_WRAP = 2;
   localparam int F_CMP1 = 3;
   localparam int F_CAP1 = 4;
   localparam int STAT_SHIFT = 3;

   // ----------------------------------------
   // Reset values and the wrap count
   // ----------------------------------------
   localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
   localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
   localparam logic [15:0] CMP_RESET    = 16'h8000;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;

endpackage

// File: hdl/tcc_timer.sv
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tcc_timer
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_cpu_irq_mask,
   input  wire logic        i_halt,
   input  wire logic        i_ext_count_clock_pin,
   input  wire logic [1:0]  i_capture_pin,
   output logic      [1:0]  o_compare_pin,
   output logic      [1:0]  o_compare_pin_en,
   output logic             o_timer_irq
);
   import tcc_pkg::*;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic        acc;
   logic        rd;
   logic        wr;
   logic [7:0]  wbyte;

   // Access acts once, at the edge before ack
   assign acc      = i_wb_cyc & i_wb_stb & ~ack_reg;
   assign rd       = acc & ~i_wb_we;
   assign wr       = acc & i_wb_we & i_wb_sel[0];
   assign wbyte    = i_wb_dat[7:0];
   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0]  ctrl1_reg;
   logic [7:0]  ctrl2_reg;
   logic [15:0] cnt_reg;
   logic        cnt_chg_reg;
   logic [7:0]  lo_buf_reg;
   logic        lo_buf_vld_reg;
   logic [4:0]  flag_reg;
   logic [4:0]  arm_reg;
   logic [15:0] cap_reg [2];
   logic [1:0]  cap_hold_reg;
   logic [15:0] cmp_reg [2];
   logic [1:0]  cmp_hold_reg;
   logic [1:0]  pin_reg;
   logic [2:0]  presc_reg;
   logic [2:0]  ext_sync_reg;
   logic [2:0]  cap_sync_reg [2];

   logic        single_mode;
   logic        pwidth_mode;
   logic        tick;
   logic        reload;
   logic [1:0]  cap_edge;
   logic [1:0]  cap_evt;
   logic [1:0]  match;
   logic        restart;
   logic [4:0]  flag_set;
   logic [4:0]  flag_clr;

   assign single_mode = ctrl2_reg[C2_SINGLE] & ~ctrl2_reg[C2_PWIDTH];
   assign pwidth_mode = ctrl2_reg[C2_PWIDTH];

   // ----------------------------------------
   // Pin synchronizers
   // ----------------------------------------
   // sync to CPU clock
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ext_sync_reg    <= 3'h0;
         cap_sync_reg[0] <= 3'h0;
         cap_sync_reg[1] <= 3'h0;
      end
      else
      begin
         ext_sync_reg    <= {ext_sync_reg[1:0], i_ext_count_clock_pin};
         cap_sync_reg[0] <= {cap_sync_reg[0][1:0], i_capture_pin[0]};
         cap_sync_reg[1] <= {cap_sync_reg[1][1:0], i_capture_pin[1]};
      end
   end

   function automatic logic edge_of(input logic [2:0] s, input logic rising);
      edge_of = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
   endfunction

   assign cap_edge[0] = edge_of(cap_sync_reg[0], ctrl1_reg[C1_CAP1_EDGE]);
   assign cap_edge[1] = edge_of(cap_sync_reg[1], ctrl2_reg[C2_CAP2_EDGE]);

   // ----------------------------------------
   // Timer clock
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         presc_reg <= 3'h0;
      else
         presc_reg <= presc_reg + 3'h1;
   end

   // Unlisted divider codes: 00 /4, 01 /2, 10 /8
   // external pin clock
   always_comb
   begin
      case (ctrl2_reg[C2_CLK_SEL_HI:C2_CLK_SEL_LO])
         2'h0:    tick = (presc_reg[1:0] == 2'h3);
         2'h1:    tick = presc_reg[0];
         2'h2:    tick = (presc_reg == 3'h7);
         default: tick = edge_of(ext_sync_reg, ctrl2_reg[C2_EXT_EDGE]);
      endcase
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // low write reload
   assign reload  = wr & (hit(i_wb_adr, ADR_CNT_LO) | hit(i_wb_adr, ADR_ACNT_LO));
   // Single-pulse start on capture one edge
   assign restart = single_mode & cap_edge[0];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_reg     <= COUNT_RELOAD;
         cnt_chg_reg <= 1'b0;
      end
      else
      begin
         cnt_chg_reg <= 1'b0;
         if (reload | restart)
         begin
            cnt_reg     <= COUNT_RELOAD;
            cnt_chg_reg <= 1'b1;
         end
         else if (tick & ~i_halt)
         begin
            cnt_reg     <= cnt_reg + 16'h1;
            cnt_chg_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lo_buf_reg     <= 8'h00;
         lo_buf_vld_reg <= 1'b0;
      end
      else if (rd & (hit(i_wb_adr, ADR_CNT_HI) | hit(i_wb_adr, ADR_ACNT_HI)))
      begin
         if (!lo_buf_vld_reg)
            lo_buf_reg <= cnt_reg[7:0];
         lo_buf_vld_reg <= 1'b1;
      end
      else if (rd & (hit(i_wb_adr, ADR_CNT_LO) | hit(i_wb_adr, ADR_ACNT_LO)))
         lo_buf_vld_reg <= 1'b0;
   end

   // ----------------------------------------
   // Capture
   // ----------------------------------------
   // capture one idle in modes
   assign cap_evt[0] = cap_edge[0] & ~cap_hold_reg[0] & ~single_mode & ~pwidth_mode;
   assign cap_evt[1] = cap_edge[1] & ~cap_hold_reg[1];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cap_reg[0]   <= 16'h0000;
         cap_reg[1]   <= 16'h0000;
         cap_hold_reg <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (cap_evt[i])
               cap_reg[i] <= cnt_reg;
         end
         if (rd & hit(i_wb_adr, ADR_CAP1_HI))
            cap_hold_reg[0] <= 1'b1;
         else if (rd & hit(i_wb_adr, ADR_CAP1_LO))
            cap_hold_reg[0] <= 1'b0;
         if (rd & hit(i_wb_adr, ADR_CAP2_HI))
            cap_hold_reg[1] <= 1'b1;
         else if (rd & hit(i_wb_adr, ADR_CAP2_LO))
            cap_hold_reg[1] <= 1'b0;
      end
   end

   // ----------------------------------------
   // Compare
   // ----------------------------------------
   // compare each timer cycle
   assign match[0] = cnt_chg_reg & (cnt_reg == cmp_reg[0]) & ~cmp_hold_reg[0];
   assign match[1] = cnt_chg_reg & (cnt_reg == cmp_reg[1]) & ~cmp_hold_reg[1];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cmp_reg[0]   <= CMP_RESET;
         cmp_reg[1]   <= CMP_RESET;
         cmp_hold_reg <= 2'h0;
      end
      else if (wr)
      begin
         case (i_wb_adr)
            ADR_CMP1_HI:
            begin
               cmp_reg[0][15:8] <= wbyte;
               cmp_hold_reg[0]  <= 1'b1;
            end
            ADR_CMP1_LO:
            begin
               cmp_reg[0][7:0]  <= wbyte;
               cmp_hold_reg[0]  <= 1'b0;
            end
            ADR_CMP2_HI:
            begin
               cmp_reg[1][15:8] <= wbyte;
               cmp_hold_reg[1]  <= 1'b1;
            end
            ADR_CMP2_LO:
            begin
               cmp_reg[1][7:0]  <= wbyte;
               cmp_hold_reg[1]  <= 1'b0;
            end
            default:
               cmp_hold_reg <= cmp_hold_reg;
         endcase
      end
   end

   // Pin latch low in reset
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         pin_reg <= 2'h0;
      else if (single_mode)
      begin
         if (restart)
            pin_reg[0] <= ctrl1_reg[C1_LEVEL2];
         else if (match[0])
            pin_reg[0] <= ctrl1_reg[C1_LEVEL1];
      end
      else if (!pwidth_mode)
      begin
         if (match[0] & ctrl2_reg[C2_PIN1_EN])
            pin_reg[0] <= ctrl1_reg[C1_LEVEL1];
         if (match[1] & ctrl2_reg[C2_PIN2_EN])
            pin_reg[1] <= ctrl1_reg[C1_LEVEL2];
         if (wr & hit(i_wb_adr, ADR_CTRL_ONE) & wbyte[C1_FORCE1])
            pin_reg[0] <= wbyte[C1_LEVEL1];
         if (wr & hit(i_wb_adr, ADR_CTRL_ONE) & wbyte[C1_FORCE2])
            pin_reg[1] <= wbyte[C1_LEVEL2];
      end
   end

   assign o_compare_pin    = pin_reg;
   assign o_compare_pin_en = {ctrl2_reg[C2_PIN2_EN], ctrl2_reg[C2_PIN1_EN]};

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Force bits are strobes, never stored
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl1_reg <= CTRL_RESET;
         ctrl2_reg <= CTRL_RESET;
      end
      else if (wr)
      begin
         if (hit(i_wb_adr, ADR_CTRL_ONE))
            ctrl1_reg <= wbyte & 8'hE7;
         if (hit(i_wb_adr, ADR_CTRL_TWO))
            ctrl2_reg <= wbyte;
      end
   end

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   always_comb
   begin
      flag_set         = 5'h00;
      flag_set[F_WRAP] = tick & ~i_halt & ~reload & ~restart & (cnt_reg == COUNT_MAX);
      flag_set[F_CAP1] = cap_evt[0] | restart;
      flag_set[F_CAP2] = cap_evt[1];
      flag_set[F_CMP1] = match[0] & ~single_mode & ~pwidth_mode;
      flag_set[F_CMP2] = match[1] & ~pwidth_mode;
      flag_clr         = 5'h00;
      if (acc)
      begin
         flag_clr[F_WRAP] = hit(i_wb_adr, ADR_CNT_LO);
         flag_clr[F_CAP1] = hit(i_wb_adr, ADR_CAP1_LO);
         flag_clr[F_CAP2] = hit(i_wb_adr, ADR_CAP2_LO);
         flag_clr[F_CMP1] = hit(i_wb_adr, ADR_CMP1_LO);
         flag_clr[F_CMP2] = hit(i_wb_adr, ADR_CMP2_LO);
      end
      flag_clr = flag_clr & arm_reg;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         flag_reg <= 5'h00;
         arm_reg  <= 5'h00;
      end
      else
      begin
         flag_reg <= flag_set | (flag_reg & ~flag_clr);
         if (rd & hit(i_wb_adr, ADR_STATUS))
            arm_reg <= flag_reg;
         else
            arm_reg <= arm_reg & ~flag_clr;
      end
   end

   assign o_timer_irq = ~i_cpu_irq_mask &
      ((ctrl1_reg[C1_WRAP_IRQ_EN] & flag_reg[F_WRAP]) |
       (ctrl1_reg[C1_CAP_IRQ_EN] & (flag_reg[F_CAP1] | flag_reg[F_CAP2])) |
       (ctrl1_reg[C1_CMP_IRQ_EN] & (flag_reg[F_CMP1] | flag_reg[F_CMP2])));

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // byte locations
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0;
      end
      else
      begin
         ack_reg <= acc;
         if (rd)
         begin
            case (i_wb_adr)
               ADR_CTRL_ONE: rdat_reg <= {24'h0, ctrl1_reg};
               ADR_CTRL_TWO: rdat_reg <= {24'h0, ctrl2_reg};
               ADR_STATUS:   rdat_reg <= {24'h0, flag_reg, 3'h0};
               ADR_CAP1_HI:  rdat_reg <= {24'h0, cap_reg[0][15:8]};
               ADR_CAP1_LO:  rdat_reg <= {24'h0, cap_reg[0][7:0]};
               ADR_CAP2_HI:  rdat_reg <= {24'h0, cap_reg[1][15:8]};
               ADR_CAP2_LO:  rdat_reg <= {24'h0, cap_reg[1][7:0]};
               ADR_CMP1_HI:  rdat_reg <= {24'h0, cmp_reg[0][15:8]};
               ADR_CMP1_LO:  rdat_reg <= {24'h0, cmp_reg[0][7:0]};
               ADR_CMP2_HI:  rdat_reg <= {24'h0, cmp_reg[1][15:8]};
               ADR_CMP2_LO:  rdat_reg <= {24'h0, cmp_reg[1][7:0]};
               ADR_CNT_HI,
               ADR_ACNT_HI:  rdat_reg <= {24'h0, cnt_reg[15:8]};
               ADR_CNT_LO,
               ADR_ACNT_LO:  rdat_reg <= {24'h0, lo_buf_vld_reg ? lo_buf_reg : cnt_reg[7:0]};
               default:      rdat_reg <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_status_read;
      rd && (i_wb_adr == ADR_STATUS) && flag_reg[F_WRAP];
   endsequence
   sequence s_main_low_access;
      acc && (i_wb_adr == ADR_CNT_LO) && arm_reg[F_WRAP] && !flag_set[F_WRAP];
   endsequence

   chk_wrap_sets_flag: assert property (flag_set[F_WRAP] |=> flag_reg[F_WRAP] && cnt_reg == 16'h0)
      else $error("wrap did not set flag");
   chk_status_arms: assert property (s_status_read |=> arm_reg[F_WRAP])
      else $error("status read did not arm wrap clear");
   chk_two_step_clear: assert property (s_main_low_access |=> !flag_reg[F_WRAP])
      else $error("wrap flag survived two step clear");
   chk_no_early_clear: assert property (flag_reg[F_WRAP] && !arm_reg[F_WRAP]
      |=> flag_reg[F_WRAP])
      else $error("wrap flag cleared without status read");
   chk_alias_keeps_flag: assert property (flag_reg[F_WRAP] && acc && i_wb_adr == ADR_ACNT_LO
      |=> flag_reg[F_WRAP])
      else $error("alias access cleared wrap flag");
   chk_lo_buffer_hold: assert property (lo_buf_vld_reg && !(rd && i_wb_adr == ADR_CNT_LO)
      && !(rd && i_wb_adr == ADR_ACNT_LO) |=> $stable(lo_buf_reg) && lo_buf_vld_reg)
      else $error("buffered low byte changed");
   chk_irq_masked: assert property (i_cpu_irq_mask |-> !o_timer_irq)
      else $error("interrupt while masked");
   chk_halt_freeze: assert property (i_halt && !reload && !restart |=> $stable(cnt_reg))
      else $error("counter moved in halt");
   chk_capture_copy: assert property (cap_evt[1] |=> cap_reg[1] == $past(cnt_reg))
      else $error("capture two missed count");
   chk_cap_inhibit: assert property (cap_hold_reg[0] |=> $stable(cap_reg[0]))
      else $error("capture one changed while held");
   chk_cmp_hold: assert property (cmp_hold_reg[1] && !flag_reg[F_CMP2] && !wr
      |=> !flag_reg[F_CMP2])
      else $error("compare fired while suspended");
   chk_reload_value: assert property (reload |=> cnt_reg == COUNT_RELOAD ##1 cnt_reg[15:2] == 14'h3FFF)
      else $error("low write did not reload");

endmodule

// File: verification/tcc_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Capture sources and count clock source
// ----------------------------------------
module tcc_pin_model
(
   input  wire logic       i_clk,
   input  wire logic       i_ext_req,
   input  wire logic [1:0] i_cap_req,
   output logic            o_ext_clk,
   output logic      [1:0] o_capture_pin
);
   logic [2:0] hold_reg;
   initial
   begin
      o_ext_clk = 1'b0;
      o_capture_pin = 2'b00;
      hold_reg = 3'h0;
   end
   // edge spacing
   // Requests inside the hold are dropped, as a slow source would
   always @(posedge i_clk)
   begin
      if (hold_reg != 3'h0)
         hold_reg <= hold_reg - 3'h1;
      else if (i_ext_req || (i_cap_req != 2'b00))
      begin
         o_ext_clk <= o_ext_clk ^ i_ext_req;
         o_capture_pin <= o_capture_pin ^ i_cap_req;
         hold_reg <= 3'h5;
      end
   end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import tcc_pkg::*;
   logic        i_clk, i_rst, cyc, stb, we, ack, mask, halt, irq, ext_req, ext_clk;
   logic [7:0]  adr, r, r2, e;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [1:0]  cap_req, cap_pin, cmp_pin, cmp_en;
   logic [15:0] v, w;
   int          fail_count, checked, n;

   tcc_timer i_tcc_timer (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_cpu_irq_mask(mask), .i_halt(halt), .i_ext_count_clock_pin(ext_clk),
      .i_capture_pin(cap_pin), .o_compare_pin(cmp_pin), .o_compare_pin_en(cmp_en),
      .o_timer_irq(irq));
   tcc_pin_model i_tcc_pin_model (.i_clk(i_clk), .i_ext_req(ext_req), .i_cap_req(cap_req),
      .o_ext_clk(ext_clk), .o_capture_pin(cap_pin));

   // ----------------------------------------
   // Bus, pin and comparison tasks
   // ----------------------------------------
   task automatic bus(input logic w_en, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int k;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_en;
      adr <= a;
      wdat <= {24'h0, d};
      k = 0;
      do
      begin
         @(posedge i_clk);
         k++;
      end
      while (ack !== 1'b1 && k < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20)
         fail_count++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, r2);
   endtask
   task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
      checked++;
      if (g !== x)
      begin
         $display("BAD %s expected %h seen %h", nm, x, g);
         fail_count++;
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] x);
      bus(1'b0, a, 8'h00, r);
      chk(nm, {8'h00, x}, {8'h00, r});
   endtask
   // One source edge, then settle through the synchronisers
   task automatic tog(input logic x, input logic [1:0] c);
      @(posedge i_clk);
      ext_req <= x;
      cap_req <= c;
      @(posedge i_clk);
      ext_req <= 1'b0;
      cap_req <= 2'b00;
      repeat (8) @(posedge i_clk);
   endtask
   task automatic pulse(input int k);
      repeat (2 * k) tog(1'b1, 2'b00);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog, scenarios
   // ----------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial
   begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      tally_and_finish;
   end
   initial
   begin
      {cyc, stb, we, ext_req, halt, mask} = 6'b000001;
      {adr, wdat, sel, cap_req} = {8'h00, 32'h0, 4'hF, 2'b00};
      fail_count = 0;
      checked = 0;
      i_rst = 1'b1;
      n = $urandom(36);
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      rchk("cmp1_hi", ADR_CMP1_HI, 8'h80);
      rchk("cmp2_lo", ADR_CMP2_LO, 8'h00);
      rchk("ctrl1", ADR_CTRL_ONE, CTRL_RESET);
      rchk("unmapped", 8'hFC, 8'h00);
      v = 16'($urandom_range(16'h1000, 16'h7FFF));
      wr(ADR_CMP2_HI, v[15:8]);
      wr(ADR_CMP2_LO, v[7:0]);
      rchk("cmp2_hi", ADR_CMP2_HI, v[15:8]);
      rchk("cmp2_lo", ADR_CMP2_LO, v[7:0]);
      wr(ADR_CTRL_TWO, 8'h0D);
      bus(1'b0, ADR_STATUS, 8'h00, r);
      wr(ADR_CNT_LO, 8'h5A);
      rchk("cnt_hi", ADR_CNT_HI, 8'hFF);
      rchk("cnt_lo", ADR_CNT_LO, 8'hFC);
      pulse(3);
      rchk("stat_nowrap", ADR_STATUS, 8'h00);
      pulse(1);
      wr(ADR_CTRL_ONE, 8'h20);
      chk("irq_masked", 16'h0, {15'h0, irq});
      mask <= 1'b0;
      @(posedge i_clk);
      chk("irq_wrap", 16'h1, {15'h0, irq});
      rchk("stat_wrap", ADR_STATUS, 8'h20);
      bus(1'b0, ADR_ACNT_LO, 8'h00, r);
      rchk("stat_alias", ADR_STATUS, 8'h20);
      bus(1'b0, ADR_CNT_LO, 8'h00, r);
      rchk("stat_clr", ADR_STATUS, 8'h00);
      chk("irq_clr", 16'h0, {15'h0, irq});
      rchk("buf_hi", ADR_CNT_HI, 8'h00);
      pulse(1);
      rchk("buf_hi2", ADR_CNT_HI, 8'h00);
      rchk("buf_lo", ADR_CNT_LO, 8'h00);
      rchk("live_lo", ADR_CNT_LO, 8'h01);
      n = $urandom_range(1, 5);
      pulse(n);
      v = 16'(n + 1);
      rchk("acnt_lo", ADR_ACNT_LO, v[7:0]);
      wr(ADR_CTRL_ONE, 8'h82);
      mask <= 1'b1;
      tog(1'b0, 2'b01);
      chk("irq_cap_mask", 16'h0, {15'h0, irq});
      mask <= 1'b0;
      @(posedge i_clk);
      chk("irq_cap", 16'h1, {15'h0, irq});
      rchk("stat_cap1", ADR_STATUS, 8'h80);
      rchk("cap1_hi", ADR_CAP1_HI, 8'h00);
      rchk("cap1_lo", ADR_CAP1_LO, v[7:0]);
      rchk("stat_cap_clr", ADR_STATUS, 8'h00);
      bus(1'b0, ADR_CAP1_HI, 8'h00, r);
      pulse(1);
      tog(1'b0, 2'b01);
      tog(1'b0, 2'b01);
      rchk("stat_held", ADR_STATUS, 8'h00);
      rchk("cap1_held", ADR_CAP1_LO, v[7:0]);
      tog(1'b0, 2'b01);
      tog(1'b0, 2'b01);
      w = v + 16'h1;
      rchk("stat_cap1b", ADR_STATUS, 8'h80);
      rchk("cap1_new", ADR_CAP1_LO, w[7:0]);
      tog(1'b0, 2'b10);
      rchk("stat_rise2", ADR_STATUS, 8'h00);
      tog(1'b0, 2'b10);
      rchk("stat_fall2", ADR_STATUS, 8'h10);
      rchk("cap2_lo", ADR_CAP2_LO, w[7:0]);
      wr(ADR_CTRL_TWO, 8'h1D);
      tog(1'b0, 2'b01);
      tog(1'b0, 2'b01);
      rchk("stat_pwidth", ADR_STATUS, 8'h00);
      wr(ADR_CTRL_TWO, 8'h8D);
      wr(ADR_CTRL_ONE, 8'h41);
      w = v + 16'h3;
      wr(ADR_CMP1_HI, w[15:8]);
      wr(ADR_CMP1_LO, w[7:0]);
      pulse(1);
      rchk("stat_nomatch", ADR_STATUS, 8'h00);
      pulse(1);
      rchk("stat_match", ADR_STATUS, 8'h40);
      chk("pin_match", 16'h0001, {14'h0, cmp_pin});
      chk("pin_en", 16'h0001, {14'h0, cmp_en});
      chk("irq_cmp", 16'h1, {15'h0, irq});
      wr(ADR_CMP1_LO, w[7:0]);
      rchk("stat_cmp_clr", ADR_STATUS, 8'h00);
      w = v + 16'h4;
      wr(ADR_CMP2_HI, w[15:8]);
      wr(ADR_CMP2_LO, w[7:0]);
      wr(ADR_CMP2_HI, w[15:8]);
      pulse(1);
      rchk("stat_suspend", ADR_STATUS, 8'h00);
      wr(ADR_CTRL_TWO, 8'hCD);
      wr(ADR_CTRL_ONE, 8'h14);
      repeat (2) @(posedge i_clk);
      chk("pin_force", 16'h0003, {14'h0, cmp_pin});
      rchk("stat_force", ADR_STATUS, 8'h00);
      wr(ADR_CTRL_TWO, 8'h04);
      halt <= 1'b1;
      bus(1'b0, ADR_ACNT_HI, 8'h00, r);
      bus(1'b0, ADR_ACNT_LO, 8'h00, e);
      repeat (20) @(posedge i_clk);
      rchk("halt_hi", ADR_ACNT_HI, r);
      rchk("halt_lo", ADR_ACNT_LO, e);
      halt <= 1'b0;
      repeat (20) @(posedge i_clk);
      bus(1'b0, ADR_ACNT_HI, 8'h00, r2);
      bus(1'b0, ADR_ACNT_LO, 8'h00, r2);
      chk("resume", 16'h1, {15'h0, r2 != e});
      // Single-pulse: capture one edge restarts, compare one ends the pulse
      wr(ADR_CMP1_HI, 8'hFF);
      wr(ADR_CMP1_LO, 8'hFE);
      wr(ADR_CTRL_ONE, 8'h0E);
      chk("pin_force_low", 16'h0002, {14'h0, cmp_pin});
      wr(ADR_CTRL_TWO, 8'hAD);
      repeat (2) tog(1'b0, 2'b01);
      chk("pulse_start", 16'h0003, {14'h0, cmp_pin});
      rchk("pulse_cnt_hi", ADR_CNT_HI, 8'hFF);
      rchk("pulse_cnt_lo", ADR_CNT_LO, 8'hFC);
      pulse(2);
      chk("pulse_end", 16'h0002, {14'h0, cmp_pin});
      rchk("stat_pulse", ADR_STATUS, 8'h80);
      tally_and_finish;
   end
endmodule
